/* File: common/exec_pkg.sv */
package exec_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PC_WIDTH = 11;
  localparam int ADDR_WIDTH = 7;
  localparam int NIB_WIDTH = 4;
  localparam int INSTR_WIDTH = 16;
  localparam int WAKE_WIDTH = 4;
  localparam int MEM_DEPTH = 128;

  // ****************************************************************
  // instruction field positions
  // ****************************************************************
  localparam int OPC9_LSB = 7;
  localparam int OPC8_LSB = 8;
  localparam int ADDR_LSB = 0;
  localparam int IMM_LSB = 4;
  localparam int WR_LSB = 0;
  localparam int SKIP2_BIT = 2;
  localparam int SKIP3_BIT = 3;

  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [8:0] OPC_SKIP_IF_BIT_TWO = 9'h114;
  localparam logic [8:0] OPC_SKIP_IF_BIT_THREE = 9'h115;
  localparam logic [8:0] OPC_SUB_MEM = 9'h034;
  localparam logic [8:0] OPC_DIFFERENCE_WITH_WRITEBACK_MEM = 9'h036;
  localparam logic [7:0] OPC_SUB_IMM = 8'h1e;
  localparam logic [7:0] OPC_DIFFERENCE_WITH_WRITEBACK_IMM = 8'h1f;
  localparam logic [15:0] OPC_STOP = 16'h0000;

  // ****************************************************************
  // program counter steps and reset values
  // ****************************************************************
  localparam logic [PC_WIDTH-1:0] PC_STEP_ONE = 11'h001;
  localparam logic [PC_WIDTH-1:0] PC_STEP_TWO = 11'h002;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 11'h000;
  localparam logic [NIB_WIDTH-1:0] ACC_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [WAKE_WIDTH-1:0] WAKE_RESET = 4'hf;

  // core state seen from outside
  typedef struct packed {
    logic [PC_WIDTH-1:0] pc;
    logic [NIB_WIDTH-1:0] main_result_register;
    logic carry_flag;
    logic zero_flag;
    logic stopped;
  } core_status_type;

  // one execution result
  typedef struct packed {
    logic [NIB_WIDTH-1:0] diff;
    logic carry_flag;
    logic zero_flag;
  } sub_result_type;

  typedef enum logic {
    st_run,
    st_stop
  } core_state_type;

endpackage

/* File: hw/nibble_ram.sv */
`timescale 1ns/1ps
module nibble_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // write port, first priority
  input wire logic wr_en_a,
  input wire logic [AW-1:0] wr_addr_a,
  input wire logic [DW-1:0] wr_data_a,
  // write port, second priority
  input wire logic wr_en_b,
  input wire logic [AW-1:0] wr_addr_b,
  input wire logic [DW-1:0] wr_data_b,
  // two combinational read ports
  input wire logic [AW-1:0] rd_addr_a,
  output logic [DW-1:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [DW-1:0] rd_data_b
);

  logic [DW-1:0] mem_ff [DEPTH];

  assign rd_data_a = mem_ff[rd_addr_a];
  assign rd_data_b = mem_ff[rd_addr_b];

  // port a wins a clash so an instruction writeback is never lost to a load
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en_a) begin
      mem_ff[wr_addr_a] <= wr_data_a;
      if (wr_en_b && (wr_addr_b != wr_addr_a)) begin
        mem_ff[wr_addr_b] <= wr_data_b;
      end
    end else if (wr_en_b) begin
      mem_ff[wr_addr_b] <= wr_data_b;
    end
  end

endmodule

/* File: hw/exec_core.sv */
`timescale 1ns/1ps
module exec_core
  import exec_pkg::*;
#(
  parameter int PCW = exec_pkg::PC_WIDTH,
  parameter int DEPTH = exec_pkg::MEM_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [exec_pkg::INSTR_WIDTH-1:0] instr_word,
  output logic instr_ready,
  // wake port, falling edge of any pin restarts from stop
  input wire logic [exec_pkg::WAKE_WIDTH-1:0] wake_port,
  // data memory preload
  input wire logic mem_load_valid,
  input wire logic [exec_pkg::ADDR_WIDTH-1:0] mem_load_addr,
  input wire logic [exec_pkg::NIB_WIDTH-1:0] mem_load_data,
  // data memory peek, answered one cycle later
  input wire logic [exec_pkg::ADDR_WIDTH-1:0] mem_peek_addr,
  output logic [exec_pkg::NIB_WIDTH-1:0] mem_peek_data,
  // core state
  output exec_pkg::core_status_type status,
  output logic osc_run,
  output logic retired,
  output logic unknown_op
);
  import exec_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  core_state_type state_ff;
  core_state_type nxt_state;
  logic [PC_WIDTH-1:0] pc_ff;
  logic [PC_WIDTH-1:0] nxt_pc;
  logic [NIB_WIDTH-1:0] acc_ff;
  logic [NIB_WIDTH-1:0] nxt_acc;
  logic carry_ff;
  logic nxt_carry;
  logic zero_ff;
  logic nxt_zero;
  logic ready_ff;
  logic osc_run_ff;
  logic retired_ff;
  logic unknown_ff;
  logic [NIB_WIDTH-1:0] peek_ff;
  logic [WAKE_WIDTH-1:0] wake_prev_ff;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic take;
  logic [8:0] opc9;
  logic [7:0] opc8;
  logic is_skip2;
  logic is_skip3;
  logic is_sub_mem;
  logic is_difference_with_writeback_mem;
  logic is_sub_imm;
  logic is_difference_with_writeback_imm;
  logic is_stop;
  logic is_sub;
  logic is_known;
  logic use_wr;
  logic [ADDR_WIDTH-1:0] mem_addr;
  logic [ADDR_WIDTH-1:0] wr_addr;
  logic [NIB_WIDTH-1:0] imm;
  logic [NIB_WIDTH-1:0] mem_rd;
  logic [NIB_WIDTH-1:0] peek_rd;

  // an instruction is only taken while the core is running and ready
  assign take = instr_valid && ready_ff;
  assign opc9 = instr_word[OPC9_LSB +: 9];
  assign opc8 = instr_word[OPC8_LSB +: 8];
  assign is_skip2 = (opc9 == OPC_SKIP_IF_BIT_TWO);
  assign is_skip3 = (opc9 == OPC_SKIP_IF_BIT_THREE);
  assign is_sub_mem = (opc9 == OPC_SUB_MEM);
  assign is_difference_with_writeback_mem = (opc9 == OPC_DIFFERENCE_WITH_WRITEBACK_MEM);
  assign is_sub_imm = (opc8 == OPC_SUB_IMM);
  assign is_difference_with_writeback_imm = (opc8 == OPC_DIFFERENCE_WITH_WRITEBACK_IMM);
  assign is_stop = (instr_word == OPC_STOP);
  assign is_sub = is_sub_mem || is_difference_with_writeback_mem || is_sub_imm || is_difference_with_writeback_imm;
  assign is_known = is_skip2 || is_skip3 || is_sub || is_stop;

  // working registers are the lowest sixteen data memory nibbles
  assign use_wr = is_sub_imm || is_difference_with_writeback_imm;
  assign wr_addr = {3'b000, instr_word[WR_LSB +: NIB_WIDTH]};
  assign imm = instr_word[IMM_LSB +: NIB_WIDTH];
  assign mem_addr = use_wr ? wr_addr : instr_word[ADDR_LSB +: ADDR_WIDTH];

  // ****************************************************************
  // subtractor
  // ****************************************************************
  logic [NIB_WIDTH-1:0] subtrahend;
  logic [NIB_WIDTH:0] diff_wide;
  sub_result_type sub_res;

  // memory forms subtract the accumulator, working register forms the immediate
  assign subtrahend = use_wr ? imm : acc_ff;
  assign diff_wide = {1'b0, mem_rd} - {1'b0, subtrahend};
  assign sub_res.diff = diff_wide[NIB_WIDTH-1:0];
  assign sub_res.carry_flag = diff_wide[NIB_WIDTH];
  assign sub_res.zero_flag = (diff_wide[NIB_WIDTH-1:0] == 4'h0);

  // writeback only for the two difference-with-writeback forms
  logic wb_en;
  assign wb_en = take && (is_difference_with_writeback_mem || is_difference_with_writeback_imm);

  // ****************************************************************
  // program counter step
  // ****************************************************************
  logic skip_hit;
  logic [PC_WIDTH-1:0] pc_step;

  // a skip jumps over exactly one instruction
  assign skip_hit = (is_skip2 && mem_rd[SKIP2_BIT]) || (is_skip3 && mem_rd[SKIP3_BIT]);
  assign pc_step = skip_hit ? PC_STEP_TWO : PC_STEP_ONE;

  // ****************************************************************
  // wake detection
  // ****************************************************************
  logic wake_fall;

  // the previous sample is kept in every state so a stale edge cannot wake
  assign wake_fall = |(wake_prev_ff & ~wake_port);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_zero = zero_ff;
    case (state_ff)
      st_run: begin
        if (take) begin
          // the stop also steps the counter so the wake resumes after it
          nxt_pc = PCW'(pc_ff + pc_step);
          if (is_stop) begin
            nxt_state = st_stop;
          end
          if (is_sub) begin
            nxt_acc = sub_res.diff;
            nxt_carry = sub_res.carry_flag;
            nxt_zero = sub_res.zero_flag;
          end
        end
      end
      st_stop: begin
        if (wake_fall) begin
          nxt_state = st_run;
        end
      end
      default: begin
        nxt_state = st_run;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= st_run;
      pc_ff <= PC_RESET;
      acc_ff <= ACC_RESET;
      carry_ff <= CARRY_RESET;
      zero_ff <= ZERO_RESET;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
    end
  end

  // handshake, clock run and event pulses
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ready_ff <= 1'b1;
      osc_run_ff <= 1'b1;
      retired_ff <= 1'b0;
      unknown_ff <= 1'b0;
      wake_prev_ff <= WAKE_RESET;
      peek_ff <= 4'h0;
    end else begin
      ready_ff <= (nxt_state == st_run);
      osc_run_ff <= (nxt_state == st_run);
      retired_ff <= take && is_known;
      unknown_ff <= take && !is_known;
      wake_prev_ff <= wake_port;
      peek_ff <= peek_rd;
    end
  end

  // ****************************************************************
  // data memory
  // ****************************************************************
  nibble_ram #(
    .DEPTH(DEPTH),
    .AW(ADDR_WIDTH),
    .DW(NIB_WIDTH)
  ) u_ram (
    .clk(sys_clk),
    .reset(reset),
    .wr_en_a(wb_en),
    .wr_addr_a(mem_addr),
    .wr_data_a(sub_res.diff),
    .wr_en_b(mem_load_valid),
    .wr_addr_b(mem_load_addr),
    .wr_data_b(mem_load_data),
    .rd_addr_a(mem_addr),
    .rd_data_a(mem_rd),
    .rd_addr_b(mem_peek_addr),
    .rd_data_b(peek_rd)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign instr_ready = ready_ff;
  assign osc_run = osc_run_ff;
  assign retired = retired_ff;
  assign unknown_op = unknown_ff;
  assign mem_peek_data = peek_ff;
  assign status.pc = pc_ff;
  assign status.main_result_register = acc_ff;
  assign status.carry_flag = carry_ff;
  assign status.zero_flag = zero_ff;
  assign status.stopped = (state_ff == st_stop);

endmodule

/* File: test/exec_core_monitor.sv */
`timescale 1ns/1ps
module exec_core_monitor
  import exec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // instruction side
  input wire logic instr_valid,
  input wire logic [exec_pkg::INSTR_WIDTH-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic [exec_pkg::WAKE_WIDTH-1:0] wake_port,
  // core state
  input wire exec_pkg::core_status_type status,
  input wire logic osc_run,
  input wire logic retired
);
  import exec_pkg::*;
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic [3:0] wake_prev_ff;
  wire logic taken = instr_valid && instr_ready;
  wire logic [8:0] op9 = instr_word[15:7];
  wire logic [7:0] op8 = instr_word[15:8];
  wire logic fall = |(wake_prev_ff & ~wake_port);
  // all four subtraction forms, the immediate writeback form included
  wire logic is_sub = op9 == OPC_SUB_MEM || op9 == OPC_DIFFERENCE_WITH_WRITEBACK_MEM || op8 == OPC_SUB_IMM ||
    op8 == OPC_DIFFERENCE_WITH_WRITEBACK_IMM;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // resets high like the core's sampler, so a pin low at release counts as a fall
  always_ff @(posedge sys_clk) begin
    wake_prev_ff <= reset ? 4'hf : wake_port;
  end
  property p_skip_two;
    taken && op9 == OPC_SKIP_IF_BIT_TWO |=> status.pc == $past(status.pc) + PC_STEP_ONE || status.pc == $past(status.pc) + PC_STEP_TWO;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip two bad pc step");
  property p_skip_three;
    taken && op9 == OPC_SKIP_IF_BIT_THREE |=> status.pc == $past(status.pc) + PC_STEP_ONE || status.pc == $past(status.pc) + PC_STEP_TWO;
  endproperty
  a_skip_three: assert property (p_skip_three) else $error("skip three bad pc step");
  property p_stop_enter;
    taken && instr_word == OPC_STOP |=> status.stopped && !osc_run && !instr_ready && retired;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");
  property p_stop_hold;
    status.stopped && !fall |=> status.stopped && $stable(status.pc);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("core moved while stopped");
  property p_wake;
    status.stopped && fall |=> !status.stopped && osc_run && instr_ready && $stable(status.pc);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after falling edge");
  property p_sub_mem;
    taken && op9 == OPC_SUB_MEM && status.main_result_register == 4'h0 |=> !status.carry_flag && retired;
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("borrow from zero subtrahend");
  property p_sub_imm;
    taken && op8 == OPC_SUB_IMM && instr_word[7:4] == 4'h0 |=> !status.carry_flag;
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("borrow from zero immediate");
  property p_sub_wb;
    taken && op9 == OPC_DIFFERENCE_WITH_WRITEBACK_MEM |=> retired && status.pc == $past(status.pc) + PC_STEP_ONE;
  endproperty
  a_sub_wb: assert property (p_sub_wb) else $error("writeback not retired");
  property p_zero;
    taken && is_sub |=> status.zero_flag == (status.main_result_register == 4'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule
bind exec_core exec_core_monitor mon (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .wake_port(wake_port), .status(status),
  .osc_run(osc_run), .retired(retired));

/* File: test/tb_bit_skip_stop_subtract_exec.sv */
`timescale 1ns/1ps
module tb_bit_skip_stop_subtract_exec;
  import exec_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    core_status_type st;
  } row_type;
  logic sys_clk;
  logic reset;
  logic instr_valid;
  logic [15:0] instr_word;
  logic instr_ready;
  logic [3:0] wake_port;
  logic mem_load_valid;
  logic [6:0] mem_load_addr;
  logic [3:0] mem_load_data;
  logic [6:0] mem_peek_addr;
  logic [3:0] mem_peek_data;
  core_status_type status;
  logic osc_run;
  logic retired;
  logic unknown_op;
  int failures;
  int checks_done;
  int n;
  // ****************************************************************
  // instruction rows, memory 3=2 5=c 6=3 7=4 beforehand
  // ****************************************************************
  row_type rows [11] = '{
    '{16'h8a05, '{11'h002, 4'h0, 1'b0, 1'b0, 1'b0}},
    '{16'h8a06, '{11'h003, 4'h0, 1'b0, 1'b0, 1'b0}},
    '{16'h8a85, '{11'h005, 4'h0, 1'b0, 1'b0, 1'b0}},
    '{16'h8a87, '{11'h006, 4'h0, 1'b0, 1'b0, 1'b0}},
    '{16'h1a07, '{11'h007, 4'h4, 1'b0, 1'b0, 1'b0}},
    '{16'h1a06, '{11'h008, 4'hf, 1'b1, 1'b0, 1'b0}},
    '{16'h1e23, '{11'h009, 4'h0, 1'b0, 1'b1, 1'b0}},
    '{16'h1e03, '{11'h00a, 4'h2, 1'b0, 1'b0, 1'b0}},
    '{16'h1e53, '{11'h00b, 4'hd, 1'b1, 1'b0, 1'b0}},
    '{16'h1b07, '{11'h00c, 4'h7, 1'b1, 1'b0, 1'b0}},
    '{16'h1f14, '{11'h00d, 4'hf, 1'b1, 1'b0, 1'b0}}
  };
  exec_core dut (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .wake_port(wake_port), .mem_load_valid(mem_load_valid),
    .mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data), .mem_peek_addr(mem_peek_addr),
    .mem_peek_data(mem_peek_data), .status(status), .osc_run(osc_run), .retired(retired),
    .unknown_op(unknown_op));
  // 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task load(input logic [6:0] a, input logic [3:0] d);
    @(posedge sys_clk);
    mem_load_valid <= 1'b1;
    mem_load_addr <= a;
    mem_load_data <= d;
  endtask
  // peek data arrives one cycle after its address
  task peek(input logic [6:0] a, input logic [3:0] e, input string name);
    @(posedge sys_clk);
    mem_peek_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(name, 18'(e), 18'(mem_peek_data));
  endtask
  // main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    wake_port = 4'hf;
    mem_load_valid = 1'b0;
    mem_load_addr = 7'h00;
    mem_load_data = 4'h0;
    mem_peek_addr = 7'h00;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("reset status", 18'h0, status);
    chk("reset ready", 18'h3, {instr_ready, osc_run});
    load(7'h03, 4'h2);
    load(7'h05, 4'hc);
    load(7'h06, 4'h3);
    load(7'h07, 4'h4);
    @(posedge sys_clk);
    mem_load_valid <= 1'b0;
    // back to back: row i is driven while row i-1 is checked
    for (int i = 0; i <= 11; i++) begin
      instr_word <= rows[i % 11].word;
      instr_valid <= i < 11;
      @(negedge sys_clk);
      if (i > 0) begin
        chk("row status", rows[i-1].st, status);
        chk("row retired", 18'h1, 18'({unknown_op, retired}));
      end
      @(posedge sys_clk);
    end
    peek(7'h03, 4'h2, "working register kept");
    peek(7'h06, 4'h3, "source kept");
    peek(7'h07, 4'h7, "writeback");
    peek(7'h04, 4'hf, "immediate writeback");
    @(posedge sys_clk);
    instr_word <= 16'hffff;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_word <= 16'h0000;
    // an unknown opcode only steps the counter and pulses its flag
    @(negedge sys_clk);
    chk("unknown", 18'({2'b10, 11'h00e}), 18'({unknown_op, retired, status.pc}));
    @(posedge sys_clk);
    instr_word <= 16'h1a05;
    @(negedge sys_clk);
    chk("stop", 18'({4'b1001, 11'h00f}), 18'({status.stopped, osc_run, instr_ready, retired, status.pc}));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("held", 18'({1'b1, 11'h00f}), 18'({status.stopped, status.pc}));
    @(posedge sys_clk);
    wake_port <= 4'he;
    // the held request is taken as soon as ready returns
    for (n = 0; n < 4 && status.stopped !== 1'b0; n++) @(negedge sys_clk);
    if (n == 4) begin
      failures++;
      results();
    end
    chk("wake", 18'({3'b011, 11'h00f}), 18'({status.stopped, osc_run, instr_ready, status.pc}));
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    wake_port <= 4'hf;
    @(negedge sys_clk);
    chk("resume", {11'h010, 4'hd, 3'b100}, status);
    results();
  end
endmodule
